//--- inc/ascd_pkg.sv
package ascd_pkg;

  localparam int CMD_W    = 32;
  localparam int RESP_W   = 48;
  localparam int CHAIN_W  = 128;
  localparam int SAMPLE_W = 24;
  localparam int NUM_CH   = 3;
  localparam int CNT_W    = 8;

  localparam int CMD_RD_BIT   = 31;
  localparam int CMD_LONG_BIT = 30;
  localparam int ADDR_HI      = 23;
  localparam int ADDR_LO      = 16;
  localparam int DATA_HI      = 15;
  localparam int DATA_LO      = 8;
  localparam int CRC_HI       = 7;

  localparam logic [7:0]  CRC8_POLY  = 8'h07;
  localparam logic [7:0]  CRC8_INIT  = 8'h00;
  localparam logic [7:0]  CRC8_XOR   = 8'h55;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [15:0] CRC16_INIT = 16'hFFFF;

  localparam int CFG_CRC_EN_BIT   = 1;
  localparam int CFG_DBG_LO       = 2;
  localparam int CFG_DBG_HI       = 3;
  localparam int FILT_RATE_HI     = 2;
  localparam int STAT_CRC_ERR_BIT = 1;

  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_FILT   = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_WAV    = 8'h10;

  localparam logic [7:0] CONFIG_RST = 8'h02;
  localparam logic [7:0] FILT_RST   = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;

  typedef enum logic [1:0] {
    DBG_NORMAL = 2'b00,
    DBG_STATIC = 2'b01,
    DBG_COUNT  = 2'b10
  } ascd_dbg_t;

  typedef enum logic [1:0] {
    EX_IDLE,
    EX_APPLY,
    EX_BUILD
  } ascd_exec_t;

  function automatic logic [7:0] ascd_crc8(input logic [23:0] d);
    logic [7:0] c;
    logic       fb;
    c = CRC8_INIT;
    for (int i = 23; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ CRC8_POLY;
      end
    end
    return c ^ CRC8_XOR;
  endfunction

  function automatic logic [15:0] ascd_crc16(input logic [31:0] d);
    logic [15:0] c;
    logic        fb;
    c = CRC16_INIT;
    for (int i = 31; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c  = {c[14:0], 1'b0};
      if (fb) begin
        c = c ^ CRC16_POLY;
      end
    end
    return c;
  endfunction

endpackage

//--- inc/ascd_stream_if.sv
`timescale 1ns/100ps
interface ascd_stream_if #(
  parameter int WIDTH = 32
) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

//--- logic/ascd_fifo.sv
`timescale 1ns/100ps
module ascd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic      ref_clk_i,
  input  wire logic      rst_n_i,
  ascd_stream_if.sink    wr,
  ascd_stream_if.source  rd
);

  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("FIFO depth must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0]                 wp;
    logic [PW:0]                 rp;
  } ascd_fifo_t;

  ascd_fifo_t s_reg;
  ascd_fifo_t s_next;
  logic       full;
  logic       empty;

  assign empty    = (s_reg.wp == s_reg.rp);
  assign full     = (s_reg.wp[PW-1:0] == s_reg.rp[PW-1:0]) &&
                    (s_reg.wp[PW] != s_reg.rp[PW]);
  assign wr.ready = ~full;
  assign rd.valid = ~empty;
  assign rd.data  = s_reg.mem[s_reg.rp[PW-1:0]];

  always_comb begin
    s_next = s_reg;
    if (wr.valid && !full) begin
      s_next.mem[s_reg.wp[PW-1:0]] = wr.data;
      s_next.wp = s_reg.wp + 1'b1;
    end
    if (rd.ready && !empty) begin
      s_next.rp = s_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

//--- logic/ascd_spi_dev.sv
// What this block does
// - Short frames are 32 or 48 clocks
// - Command echo byte leads the response
// - Checksum trails only in 48-clock frames
// - Capture MOSI on rising clock, select low
// - MISO released while select is high
// - Response answers the previous frame's command
// - Read returns next address, address, status
// - Sample address returns full 24-bit value
// - Write answer reads back written register
// - Chain passes stream, decodes last 32
// - Dedicated select: each device stands alone
// - Config bits 3:2 select sample mode
// - Static mode holds samples until written
// - Count mode increments once per sample
// - Command checksum poly 07, xor 55
// - Bad checksum flags status, drops command
// - Echo holds direction, length, error, pending
// - Response checksum is false-CCITT 16-bit
`timescale 1ns/100ps
module ascd_spi_dev
  import ascd_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       sclk_i,
  input  wire logic                       cs_n_i,
  input  wire logic                       mosi_i,
  output logic                            miso_o,
  output logic                            miso_oe_n_o,
  input  wire logic                       adc_valid_i,
  input  wire logic [NUM_CH*SAMPLE_W-1:0] adc_data_i,
  input  wire logic                       irq_pending_i,
  output logic [NUM_CH*SAMPLE_W-1:0]      sample_word_regs_o,
  output logic                            sample_ready_strobe_o,
  output logic [1:0]                      waveform_test_mode_o,
  output logic [FILT_RATE_HI:0]           output_rate_select_o,
  output logic                            crc_check_en_o,
  output logic                            crc_fail_o
);

  generate
    if (NUM_CH * 3 > 8'hF0 - ADDR_WAV) begin : g_bad_map
      $error("Sample registers do not fit the address space");
    end
  endgenerate

  typedef struct packed {
    logic [2:0]                           sclk_sync;
    logic [2:0]                           cs_sync;
    logic [1:0]                           mosi_sync;
    logic [CNT_W-1:0]                     nbits;
    logic [CMD_W-1:0]                     rx;
    logic                                 rx_bit;
    logic [CHAIN_W-1:0]                   tx;
    logic [CHAIN_W-1:0]                   resp;
    logic                                 pend_valid;
    logic [CMD_W-1:0]                     pend_cmd;
    ascd_exec_t                           ex;
    logic [CMD_W-1:0]                     cmd;
    logic                                 cmd_bad;
    logic [7:0]                           cfg;
    logic [7:0]                           filt;
    logic [7:0]                           status;
    logic [NUM_CH-1:0][SAMPLE_W-1:0]      wav;
    logic                                 miso_oe_n;
    logic                                 strobe;
  } ascd_state_t;

  localparam ascd_state_t RESET_STATE = '{
    cs_sync:   3'h7,
    ex:        EX_IDLE,
    cfg:       CONFIG_RST,
    filt:      FILT_RST,
    status:    STATUS_RST,
    miso_oe_n: 1'b1,
    default:   '0
  };

  ascd_state_t s_reg;
  ascd_state_t s_next;

  ascd_stream_if #(.WIDTH(CMD_W)) cmd_in ();
  ascd_stream_if #(.WIDTH(CMD_W)) cmd_out ();

  ascd_fifo #(
    .WIDTH (CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr        (cmd_in.sink),
    .rd        (cmd_out.source)
  );

  // Commands queue until the executor is idle and no frame runs
  assign cmd_in.valid  = s_reg.pend_valid;
  assign cmd_in.data   = s_reg.pend_cmd;
  assign cmd_out.ready = (s_reg.ex == EX_IDLE) && s_reg.cs_sync[1];

  function automatic logic [7:0] rd_byte(input ascd_state_t st,
                                         input logic [7:0]  a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_CONFIG: v = st.cfg;
      ADDR_FILT:   v = st.filt;
      ADDR_STATUS: v = st.status;
      default:     v = 8'h00;
    endcase
    for (int c = 0; c < NUM_CH; c++) begin
      for (int b = 0; b < 3; b++) begin
        if (a == ADDR_WAV + 8'(3 * c + b)) begin
          v = st.wav[c][SAMPLE_W-1-8*b -: 8];
        end
      end
    end
    return v;
  endfunction

  always_comb begin
    logic                 cs_low;
    logic                 sclk_rise;
    logic                 sclk_fall;
    logic                 cs_rise;
    logic                 cs_fall;
    logic                 crc_ok;
    logic [7:0]           addr;
    logic [7:0]           wdata;
    logic [7:0]           echo;
    logic [SAMPLE_W-1:0]  payload;
    logic [CMD_W-1:0]     resp32;
    logic                 wav_hit;
    cs_low    = 1'b0;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    cs_rise   = 1'b0;
    cs_fall   = 1'b0;
    crc_ok    = 1'b0;
    addr      = 8'h00;
    wdata     = 8'h00;
    echo      = 8'h00;
    payload   = '0;
    resp32    = '0;
    wav_hit   = 1'b0;
    s_next    = s_reg;

    s_next.sclk_sync = {s_reg.sclk_sync[1:0], sclk_i};
    s_next.cs_sync   = {s_reg.cs_sync[1:0], cs_n_i};
    s_next.mosi_sync = {s_reg.mosi_sync[0], mosi_i};

    cs_low    = ~s_reg.cs_sync[1];
    cs_rise   = s_reg.cs_sync[1] & ~s_reg.cs_sync[2];
    cs_fall   = ~s_reg.cs_sync[1] & s_reg.cs_sync[2];
    sclk_rise = s_reg.sclk_sync[1] & ~s_reg.sclk_sync[2];
    sclk_fall = ~s_reg.sclk_sync[1] & s_reg.sclk_sync[2];

    s_next.miso_oe_n = s_reg.cs_sync[1];

    if (cs_fall) begin
      s_next.nbits = '0;
    end else if (cs_low && sclk_rise) begin
      s_next.rx     = {s_reg.rx[CMD_W-2:0], s_reg.mosi_sync[1]};
      s_next.rx_bit = s_reg.mosi_sync[1];
      if (s_reg.nbits != '1) begin
        s_next.nbits = s_reg.nbits + 1'b1;
      end
    end

    // Response staged by the last command goes out in this frame
    if (cs_fall) begin
      s_next.tx = s_reg.resp;
    end else if (cs_low && sclk_fall) begin
      s_next.tx = {s_reg.tx[CHAIN_W-2:0], s_reg.rx_bit};
    end

    // Only the last 32 bits held at select release form the command
    if (cs_rise && s_reg.nbits >= CNT_W'(CMD_W)) begin
      s_next.pend_valid = 1'b1;
      s_next.pend_cmd   = s_reg.rx;
    end else if (cmd_in.ready) begin
      s_next.pend_valid = 1'b0;
    end

    s_next.strobe = adc_valid_i;
    case (s_reg.cfg[CFG_DBG_HI:CFG_DBG_LO])
      DBG_STATIC: begin
        s_next.wav = s_reg.wav;
      end
      DBG_COUNT: begin
        if (adc_valid_i) begin
          for (int c = 0; c < NUM_CH; c++) begin
            s_next.wav[c] = s_reg.wav[c] + 1'b1;
          end
        end
      end
      default: begin
        if (adc_valid_i) begin
          s_next.wav = adc_data_i;
        end
      end
    endcase

    addr  = s_reg.cmd[ADDR_HI:ADDR_LO];
    wdata = s_reg.cmd[DATA_HI:DATA_LO];

    case (s_reg.ex)
      EX_IDLE: begin
        if (cmd_out.valid && cmd_out.ready) begin
          s_next.cmd = cmd_out.data;
          s_next.ex  = EX_APPLY;
        end
      end
      EX_APPLY: begin
        crc_ok = ~s_reg.cfg[CFG_CRC_EN_BIT] ||
                 (ascd_crc8(s_reg.cmd[CMD_W-1:DATA_LO]) ==
                  s_reg.cmd[CRC_HI:0]);
        s_next.cmd_bad = ~crc_ok;
        if (crc_ok && !s_reg.cmd[CMD_RD_BIT]) begin
          case (addr)
            ADDR_CONFIG: s_next.cfg = wdata;
            ADDR_FILT:   s_next.filt = wdata;
            ADDR_STATUS: s_next.status = s_reg.status & ~wdata;
            default:     s_next.cfg = s_reg.cfg;
          endcase
          for (int c = 0; c < NUM_CH; c++) begin
            for (int b = 0; b < 3; b++) begin
              if (addr == ADDR_WAV + 8'(3 * c + b)) begin
                s_next.wav[c][SAMPLE_W-1-8*b -: 8] = wdata;
              end
            end
          end
        end
        if (!crc_ok) begin
          s_next.status[STAT_CRC_ERR_BIT] = 1'b1;
        end
        s_next.ex = EX_BUILD;
      end
      EX_BUILD: begin
        echo = {s_reg.cmd[CMD_RD_BIT], s_reg.cmd[CMD_LONG_BIT], 4'h0,
                s_reg.cmd_bad, irq_pending_i};
        for (int c = 0; c < NUM_CH; c++) begin
          for (int b = 0; b < 3; b++) begin
            if (addr == ADDR_WAV + 8'(3 * c + b)) begin
              wav_hit = 1'b1;
              payload = s_reg.wav[c];
            end
          end
        end
        if (s_reg.cmd_bad) begin
          payload = {16'h0000, s_reg.status};
        end else if (!s_reg.cmd[CMD_RD_BIT]) begin
          payload = {addr, rd_byte(s_reg, addr), s_reg.status};
        end else if (!wav_hit) begin
          payload = {rd_byte(s_reg, addr + 8'h01), rd_byte(s_reg, addr),
                     s_reg.status};
        end else begin
          payload = payload;
        end
        resp32 = {echo, payload};
        s_next.resp = {resp32, ascd_crc16(resp32),
                       (CHAIN_W - RESP_W)'(0)};
        s_next.ex   = EX_IDLE;
      end
      default: begin
        s_next.ex = EX_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign miso_o                = s_reg.tx[CHAIN_W-1];
  assign miso_oe_n_o           = s_reg.miso_oe_n;
  assign sample_word_regs_o    = s_reg.wav;
  assign sample_ready_strobe_o = s_reg.strobe;
  assign waveform_test_mode_o  = s_reg.cfg[CFG_DBG_HI:CFG_DBG_LO];
  assign output_rate_select_o  = s_reg.filt[FILT_RATE_HI:0];
  assign crc_check_en_o        = s_reg.cfg[CFG_CRC_EN_BIT];
  assign crc_fail_o            = s_reg.status[STAT_CRC_ERR_BIT];

endmodule

//--- testbench/ascd_chk.sv
`timescale 1ns/100ps
module ascd_chk
  import ascd_pkg::*;
(
  input wire logic                       ref_clk_i,
  input wire logic                       rst_n_i,
  input wire logic                       cs_n_i,
  input wire logic                       miso_oe_n_o,
  input wire logic                       adc_valid_i,
  input wire logic [NUM_CH*SAMPLE_W-1:0] adc_data_i,
  input wire logic [NUM_CH*SAMPLE_W-1:0] sample_word_regs_o,
  input wire logic                       sample_ready_strobe_o,
  input wire logic [1:0]                 waveform_test_mode_o,
  input wire logic                       crc_check_en_o,
  input wire logic                       crc_fail_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_sel;
    $fell(cs_n_i) ##1 !cs_n_i;
  endsequence
  sequence s_one_sample;
    adc_valid_i ##1 !adc_valid_i;
  endsequence

  property p_oe_on;
    s_sel |-> ##[1:3] !miso_oe_n_o;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("miso not driven in frame");
  property p_oe_off;
    cs_n_i [*5] |-> miso_oe_n_o;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("miso driven while idle");
  property p_strobe;
    s_one_sample |-> sample_ready_strobe_o ##1 !sample_ready_strobe_o;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("sample strobe wrong");
  property p_normal;
    adc_valid_i && waveform_test_mode_o != DBG_STATIC &&
      waveform_test_mode_o != DBG_COUNT |=>
      sample_word_regs_o == $past(adc_data_i);
  endproperty
  a_normal: assert property (p_normal)
    else $error("sample not loaded");
  property p_static;
    adc_valid_i && waveform_test_mode_o == DBG_STATIC |=>
      $stable(sample_word_regs_o);
  endproperty
  a_static: assert property (p_static)
    else $error("static sample moved");
  property p_count;
    adc_valid_i && waveform_test_mode_o == DBG_COUNT |=> sample_word_regs_o ==
      {$past(sample_word_regs_o[71:48]) + 24'h000001,
       $past(sample_word_regs_o[47:24]) + 24'h000001,
       $past(sample_word_regs_o[23:0]) + 24'h000001};
  endproperty
  a_count: assert property (p_count)
    else $error("count step wrong");
  property p_rst_cfg;
    $rose(rst_n_i) |-> crc_check_en_o && !crc_fail_o &&
      waveform_test_mode_o == 2'b00;
  endproperty
  a_rst_cfg: assert property (p_rst_cfg)
    else $error("reset state wrong");
  property p_fail_set;
    $rose(crc_fail_o) |-> cs_n_i && crc_check_en_o;
  endproperty
  a_fail_set: assert property (p_fail_set)
    else $error("bad flag set");
  property p_cfg_quiet;
    $changed(waveform_test_mode_o) |-> cs_n_i && $past(cs_n_i, 2);
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("config mid frame");
endmodule

bind ascd_spi_dev ascd_chk i_ascd_chk (
  .ref_clk_i,
  .rst_n_i,
  .cs_n_i,
  .miso_oe_n_o,
  .adc_valid_i,
  .adc_data_i,
  .sample_word_regs_o,
  .sample_ready_strobe_o,
  .waveform_test_mode_o,
  .crc_check_en_o,
  .crc_fail_o
);

//--- testbench/ascd_host.sv
`timescale 1ns/100ps
module ascd_host (
  input  wire logic ref_clk_i,
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Command occupies the last 32 bits, length fixed by caller
  // Lone device on its own select, never chained
  task automatic xfer(input logic [47:0] tx, input int n,
                      output logic [47:0] rx);
    rx = '0;
    @(negedge ref_clk_i);
    cs_n_o = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      mosi_o = tx[i];
      repeat (5) @(negedge ref_clk_i);
      rx = {rx[46:0], miso_i};
      sclk_o = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge ref_clk_i);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    rx = rx << (48 - n);
    repeat (14) @(negedge ref_clk_i);
  endtask
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import ascd_pkg::*;

  localparam logic [71:0] dat_a = 72'h123456_ABCDEF_0F1E2D;
  localparam logic [71:0] dat_c = 72'h123457_ABCDF0_0F1E2E;
  localparam logic [71:0] dat_b = 72'h00FF00_5A5A5A_800001;

  logic        ref_clk_i;
  logic        rst_n_i;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  wire         miso;
  logic        miso_d;
  logic        oe_n;
  logic        adc_valid;
  logic [71:0] adc_data;
  logic        irq;
  logic [71:0] regs;
  logic        strobe;
  logic [1:0]  mode;
  logic [2:0]  rate;
  logic        chk_en;
  logic        fail;
  int          n_fail;
  int          tests_run;

  assign miso = oe_n ? 1'bz : miso_d;

  ascd_spi_dev #(.FIFO_DEPTH(4)) i_ascd_spi_dev (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .mosi_i(mosi), .miso_o(miso_d), .miso_oe_n_o(oe_n),
    .adc_valid_i(adc_valid), .adc_data_i(adc_data), .irq_pending_i(irq),
    .sample_word_regs_o(regs), .sample_ready_strobe_o(strobe),
    .waveform_test_mode_o(mode), .output_rate_select_o(rate),
    .crc_check_en_o(chk_en), .crc_fail_o(fail));

  ascd_host i_ascd_host (.ref_clk_i(ref_clk_i), .miso_i(miso),
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

  function automatic logic [15:0] crc(input logic [31:0] d, input int n,
      input int w, input logic [15:0] p, input logic [15:0] c);
    for (int i = n - 1; i >= 0; i--)
      c = (c << 1) ^ ((c[w-1] ^ d[i]) ? p : 16'h0000);
    return c & ((17'h1 << w) - 1);
  endfunction

  function automatic logic [31:0] mk(input logic rd, input logic [7:0] a,
      input logic [7:0] d, input logic bad);
    logic [23:0] h;
    logic [15:0] c;
    h = {rd, 1'b0, 6'h00, a, d};
    c = crc({8'h00, h}, 24, 8, 16'h0007, 16'h0000);
    return {h, c[7:0] ^ 8'h55 ^ {7'h00, bad}};
  endfunction

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic f(input logic rd, input logic [7:0] a, input logic [7:0] d,
      input logic bad, input int n, input logic [31:0] exp);
    logic [47:0] rx;
    i_ascd_host.xfer({16'h0000, mk(rd, a, d, bad)}, n, rx);
    chk(rx[47:16], exp);
    if (n == 48)
      chk(rx[15:0],
          crc(rx[47:16], 32, 16, 16'h1021, 16'hFFFF));
  endtask

  task automatic pulse(input logic [71:0] v, input logic [71:0] exp);
    @(negedge ref_clk_i);
    adc_data = v;
    adc_valid = 1'b1;
    @(negedge ref_clk_i);
    adc_valid = 1'b0;
    @(negedge ref_clk_i);
    chk(regs, exp);
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    repeat (30000) @(posedge ref_clk_i);
    n_fail++;
    end_of_test();
  end

  initial begin
    n_fail = 0;
    tests_run = 0;
    rst_n_i = 1'b0;
    adc_valid = 1'b0;
    adc_data = '0;
    irq = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    chk({chk_en, fail, mode}, 4'h8);
    pulse(dat_a, dat_a);
    f(1'b1, 8'h00, 8'h00, 1'b0, 32, 32'h00000000);
    f(1'b0, 8'h00, 8'h0A, 1'b0, 48, 32'h81000200);
    chk(mode, DBG_COUNT);
    pulse(dat_a, dat_c);
    f(1'b1, 8'h10, 8'h00, 1'b0, 48, 32'h01000A00);
    f(1'b0, 8'h00, 8'h06, 1'b0, 32, 32'h810F1E2E);
    pulse(dat_b, dat_c);
    f(1'b0, 8'h00, 8'h0E, 1'b0, 32, 32'h01000600);
    pulse(dat_b, dat_b);
    f(1'b0, 8'h01, 8'h05, 1'b1, 32, 32'h01000E00);
    chk({fail, rate}, 4'h8);
    f(1'b0, 8'h02, 8'h02, 1'b0, 32, 32'h03000002);
    chk(fail, 1'b0);
    f(1'b0, 8'h00, 8'h00, 1'b0, 32, 32'h01020000);
    chk(chk_en, 1'b0);
    f(1'b0, 8'h00, 8'h04, 1'b1, 32, 32'h01000000);
    chk(mode, DBG_STATIC);
    f(1'b1, 8'h01, 8'h00, 1'b0, 32, 32'h01000400);
    f(1'b0, 8'h10, 8'h5A, 1'b0, 32, 32'h81000000);
    f(1'b1, 8'h10, 8'h00, 1'b0, 32, 32'h01105A00);
    f(1'b0, 8'h00, 8'h00, 1'b0, 32, 32'h815A0001);
    chk(regs, 72'h00FF00_5A5A5A_5A0001);
    end_of_test();
  end
endmodule
